/* File: hdl/bwss_cfg.svh */
`ifndef BWSS_CFG_SVH
`define BWSS_CFG_SVH
// Register byte offsets
`define BWSS_IO_OFF 12'h01c
`define BWSS_MEM_OFF 12'h020
`define BWSS_IRQ_STS_OFF 12'h100
`define BWSS_IRQ_MSK_OFF 12'h104
// Fixed I/O addressing code, bits 11:8
`define BWSS_IO_CODE 4'h1
`define BWSS_IO_CODE_LSB 8
`define BWSS_IO_LIM_LSB 12
`define BWSS_MEM_BASE_LSB 4
// Status flag positions in the 0x1c word
`define BWSS_MDPE_POS 24
`define BWSS_STA_POS 27
`define BWSS_RTA_POS 28
`define BWSS_RMA_POS 29
`define BWSS_RSE_POS 30
`define BWSS_DPE_POS 31
// Flag index in the compact view
`define BWSS_F_MDPE 0
`define BWSS_F_STA 1
`define BWSS_F_RTA 2
`define BWSS_F_RMA 3
`define BWSS_F_RSE 4
`define BWSS_F_DPE 5
`define BWSS_NFLAG 6
// Reset values and fixed window low-bit fills
`define BWSS_IO_LIM_RST 4'h0
`define BWSS_MEM_BASE_RST 12'h000
`define BWSS_MASK_RST 6'h00
`define BWSS_IO_LOW_ONES 12'hfff
`define BWSS_MEM_LOW_ONES 20'hfffff
`endif

/* File: hdl/bwss_pkg.sv */
package bwss_pkg;
  // Error and abort events from the port's transaction logic
  typedef struct packed {
    logic par_err;
    logic cpl_abort_sent;
    logic cpl_abort_rcvd;
    logic cpl_ur_rcvd;
    logic err_msg_sent;
    logic poisoned_rcvd;
  } bwss_events_t;
  // Window setup owned by neighbouring registers
  typedef struct packed {
    logic [3:0] io_base_nib;
    logic [15:0] io_base_upper;
    logic [15:0] io_limit_upper;
    logic [11:0] mem_limit;
  } bwss_win_t;
  // Bridge control enables
  typedef struct packed {
    logic perr_resp_en;
    logic serr_en;
  } bwss_ctl_t;
endpackage

/* File: hdl/bwss_regs.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "bwss_cfg.svh"
// Notes on behaviour
// [RULE1] I/O limit bits 11:8 read fixed code
// [RULE2] Writable I/O limit nibble, resets zero
// [RULE3] I/O top low bits ones, upper external
// [RULE4] Legacy PCI status bits read zero
// [RULE5] Parity event sets bit 24
// [RULE6] Bit 24 gated by parity response enable
// [RULE7] Completer abort sent sets bit 27
// [RULE8] Completer abort received sets bit 28
// [RULE9] Unsupported request received sets bit 29
// [RULE10] Error message with enable sets bit 30
// [RULE11] Poisoned packet received sets bit 31
// [RULE12] Writable memory base bits 15:4
// [RULE13] Memory bottom low bits zero, resets zero
// [RULE14] Memory top low twenty bits ones
// [RULE15] I/O bottom low twelve bits zero
// [RULE16] Write one clears, events win
// [RULE17] Inside window when base to limit
// [RULE18] Reserved bits read zero, ignore writes
module bwss_regs
  import bwss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bwss_events_t events,
  input wire bwss_win_t win,
  input wire bwss_ctl_t ctl,
  input wire logic [31:0] io_chk_addr,
  input wire logic [31:0] mem_chk_addr,
  output logic io_hit,
  output logic mem_hit,
  output logic irq
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic pready_q;
  logic pslverr_q;
  logic map_d;
  logic setup;
  logic wr_en;
  logic [3:0] io_lim_q;
  logic [11:0] mem_base_q;
  logic [`BWSS_NFLAG-1:0] sts_q;
  logic [`BWSS_NFLAG-1:0] sts_set;
  logic [`BWSS_NFLAG-1:0] sts_clr;
  logic [`BWSS_NFLAG-1:0] mask_q;
  logic irq_q;
  logic io_hit_q;
  logic mem_hit_q;
  logic [31:0] io_lo;
  logic [31:0] io_hi;
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;

  assign setup = psel && !penable && !pready_q;
  // Writes land only at the completing access edge
  assign wr_en = psel && penable && pready_q && pwrite;

  // Read word assembly; unlisted bits stay zero
  always_comb
  begin
    rd_d = 32'h0000_0000; // RULE18
    map_d = 1'b1;
    case (paddr)
      `BWSS_IO_OFF:
      begin
        rd_d[3:0] = `BWSS_IO_CODE;
        rd_d[7:4] = win.io_base_nib;
        rd_d[11:8] = `BWSS_IO_CODE; // RULE1
        rd_d[15:12] = io_lim_q;
        // Bits 21, 23, 26:25 have no storage and read zero
        rd_d[`BWSS_MDPE_POS] = sts_q[`BWSS_F_MDPE]; // RULE4
        rd_d[`BWSS_STA_POS] = sts_q[`BWSS_F_STA];
        rd_d[`BWSS_RTA_POS] = sts_q[`BWSS_F_RTA];
        rd_d[`BWSS_RMA_POS] = sts_q[`BWSS_F_RMA];
        rd_d[`BWSS_RSE_POS] = sts_q[`BWSS_F_RSE];
        rd_d[`BWSS_DPE_POS] = sts_q[`BWSS_F_DPE];
      end
      `BWSS_MEM_OFF:
      begin
        rd_d[15:4] = mem_base_q; // RULE18
        rd_d[31:20] = win.mem_limit;
      end
      `BWSS_IRQ_STS_OFF: rd_d[`BWSS_NFLAG-1:0] = sts_q;
      `BWSS_IRQ_MSK_OFF: rd_d[`BWSS_NFLAG-1:0] = mask_q;
      default: map_d = 1'b0;
    endcase
  end

  // One wait state: answer is ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !map_d;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ************************************************************
  // Window fields and interrupt mask
  // ************************************************************
  // Software-owned limit and base; reserved write bits dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_lim_q <= `BWSS_IO_LIM_RST; // RULE2
      mem_base_q <= `BWSS_MEM_BASE_RST; // RULE13
      mask_q <= `BWSS_MASK_RST;
    end
    else if (wr_en && !pslverr_q)
    begin
      if (paddr == `BWSS_IO_OFF)
        io_lim_q <= pwdata[`BWSS_IO_LIM_LSB +: 4]; // RULE2
      if (paddr == `BWSS_MEM_OFF)
        mem_base_q <= pwdata[`BWSS_MEM_BASE_LSB +: 12]; // RULE12
      if (paddr == `BWSS_IRQ_MSK_OFF)
        mask_q <= pwdata[`BWSS_NFLAG-1:0];
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // Event qualification; parity flag needs its response enable
  always_comb
  begin
    sts_set = '0;
    sts_set[`BWSS_F_MDPE] = events.par_err && ctl.perr_resp_en; // RULE5 RULE6
    sts_set[`BWSS_F_STA] = events.cpl_abort_sent; // RULE7
    sts_set[`BWSS_F_RTA] = events.cpl_abort_rcvd; // RULE8
    sts_set[`BWSS_F_RMA] = events.cpl_ur_rcvd; // RULE9
    sts_set[`BWSS_F_RSE] = events.err_msg_sent && ctl.serr_en; // RULE10
    sts_set[`BWSS_F_DPE] = events.poisoned_rcvd; // RULE11
  end

  // Both the status word and the compact view clear by writing ones
  always_comb
  begin
    sts_clr = '0;
    if (wr_en && paddr == `BWSS_IO_OFF)
    begin
      sts_clr[`BWSS_F_MDPE] = pwdata[`BWSS_MDPE_POS]; // RULE16
      sts_clr[`BWSS_F_STA] = pwdata[`BWSS_STA_POS];
      sts_clr[`BWSS_F_RTA] = pwdata[`BWSS_RTA_POS];
      sts_clr[`BWSS_F_RMA] = pwdata[`BWSS_RMA_POS];
      sts_clr[`BWSS_F_RSE] = pwdata[`BWSS_RSE_POS];
      sts_clr[`BWSS_F_DPE] = pwdata[`BWSS_DPE_POS];
    end
    else if (wr_en && paddr == `BWSS_IRQ_STS_OFF)
      sts_clr = pwdata[`BWSS_NFLAG-1:0];
  end

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sts_q <= '0;
    else
      sts_q <= (sts_q & ~sts_clr) | sts_set; // RULE16
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(sts_q & mask_q);
  end

  // ************************************************************
  // Forwarding decision
  // ************************************************************
  // Assembled window edges
  assign io_lo = {win.io_base_upper, win.io_base_nib, 12'h000}; // RULE15
  assign io_hi = {win.io_limit_upper, io_lim_q, `BWSS_IO_LOW_ONES}; // RULE3
  assign mem_lo = {mem_base_q, 20'h00000}; // RULE13
  assign mem_hi = {win.mem_limit, `BWSS_MEM_LOW_ONES}; // RULE14

  // Registered compare costs a cycle but keeps outputs clean
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_hit_q <= 1'b0;
      mem_hit_q <= 1'b0;
    end
    else
    begin
      io_hit_q <= io_chk_addr >= io_lo && io_chk_addr <= io_hi; // RULE17
      mem_hit_q <= mem_chk_addr >= mem_lo && mem_chk_addr <= mem_hi; // RULE17
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign io_hit = io_hit_q;
  assign mem_hit = mem_hit_q;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_setup;
    psel && !penable && !pready_q;
  endsequence

  sequence s_access;
    psel && penable && pready_q;
  endsequence

  sequence s_rd_mem;
    s_setup and (!pwrite && paddr == `BWSS_MEM_OFF);
  endsequence

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> s_access ##1 !pready_q)
    else $error("APB answer not one wait state");

  a_io_fixed_code: assert property (@(posedge pclk) disable iff (!presetn) // RULE1 RULE4
    s_setup and (!pwrite && paddr == `BWSS_IO_OFF) |=>
      prdata_q[11:8] == 4'h1 && prdata_q[23:21] == 3'b000 && prdata_q[26:25] == 2'b00
      && prdata_q[20:16] == 5'h00)
    else $error("I/O limit code or legacy bits wrong");

  a_mdpe_gated: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    $rose(sts_q[`BWSS_F_MDPE]) |-> $past(ctl.perr_resp_en))
    else $error("Parity flag set while response disabled");

  a_mdpe_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    events.par_err && ctl.perr_resp_en |=> sts_q[`BWSS_F_MDPE])
    else $error("Parity flag not set");

  a_abort_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    events.cpl_abort_sent |=> sts_q[`BWSS_F_STA])
    else $error("Sent abort flag not set");

  a_rta_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    events.cpl_abort_rcvd |=> sts_q[`BWSS_F_RTA])
    else $error("Received abort flag not set");

  a_rma_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    events.cpl_ur_rcvd |=> sts_q[`BWSS_F_RMA])
    else $error("Unsupported request flag not set");

  a_rse_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    events.err_msg_sent && ctl.serr_en |=> sts_q[`BWSS_F_RSE])
    else $error("System error flag not set");

  a_sys_err_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    $rose(sts_q[`BWSS_F_RSE]) |-> $past(events.err_msg_sent && ctl.serr_en))
    else $error("System error flag set without cause");

  a_poison_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE11 RULE16
    events.poisoned_rcvd |=> sts_q[`BWSS_F_DPE])
    else $error("Poisoned flag lost");

  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    wr_en && paddr == `BWSS_IO_OFF && pwdata[`BWSS_DPE_POS] && !events.poisoned_rcvd
      |=> !sts_q[`BWSS_F_DPE])
    else $error("Write one did not clear flag");

  a_mem_base_wr: assert property (@(posedge pclk) disable iff (!presetn) // RULE12 RULE18
    wr_en && paddr == `BWSS_MEM_OFF |=> mem_base_q == $past(pwdata[15:4]))
    else $error("Memory base not stored");

  a_mem_rsvd_rd: assert property (@(posedge pclk) disable iff (!presetn) // RULE13 RULE18
    s_rd_mem |=> prdata_q[19:0] == {4'h0, $past(mem_base_q), 4'h0})
    else $error("Memory base read or reserved bits wrong");

  a_io_lim_wr: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    wr_en && paddr == `BWSS_IO_OFF |=> io_lim_q == $past(pwdata[15:12]))
    else $error("I/O limit not stored");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup and (!map_d) |=> pslverr_q && prdata_q == 32'h0000_0000)
    else $error("Unmapped access not refused");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_q == |($past(sts_q) & $past(mask_q)))
    else $error("Interrupt level wrong");

endmodule

/* File: tb/bwss_apb_host.sv */
`timescale 1ns/1ps
// ****************
// Config host
// ****************
module bwss_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; no latency assumed, waits for pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: tb/bridge_window_secondary_status_test.sv */
`timescale 1ns/1ps
`include "bwss_cfg.svh"
// ****************
// Bench
// ****************
module bridge_window_secondary_status_test
  import bwss_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, io_hit, mem_hit, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, d, ia, ma, lo, hi, mlo, mhi;
  logic [63:0] rv;
  bwss_events_t events = '0;
  bwss_win_t win = '0;
  bwss_win_t w;
  bwss_ctl_t ctl = 2'h3;
  logic [31:0] io_chk_addr = 32'h0;
  logic [31:0] mem_chk_addr = 32'h0;
  logic [3:0] lim = 4'h0;
  logic [11:0] mb = 12'h000;
  int error_cnt = 0;
  int check_count = 0;
  int pos[6] = '{24, 27, 28, 29, 30, 31};
  int k;
  // Clock at 5 ns
  always #2.5 pclk = ~pclk;
  bwss_apb_host i_bwss_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bwss_regs i_bwss_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .win(win), .ctl(ctl), .io_chk_addr(io_chk_addr),
    .mem_chk_addr(mem_chk_addr), .io_hit(io_hit), .mem_hit(mem_hit), .irq(irq));
  // Expected words, built from field layout
  function automatic logic [31:0] e1c(input logic [5:0] f);
    e1c = {f[5:1], 2'h0, f[0], 8'h00, lim, 4'h1, win.io_base_nib, 4'h1};
  endfunction
  function automatic logic [31:0] e20();
    e20 = {win.mem_limit, 4'h0, mb, 4'h0};
  endfunction
  function automatic logic [31:0] corner(input int c, input logic [31:0] l, h);
    corner = (c == 0) ? l : (c == 1) ? h : (c == 2) ? h + 32'h1 : l - 32'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    i_bwss_apb_host.xfer(1'b1, a, v, r, e);
  endtask
  // Read, compare data and error flag
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic er);
    i_bwss_apb_host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, er});
  endtask
  // One-cycle event, flag 0 is the MSB of the struct
  task automatic pulse(input int i);
    @(posedge pclk);
    events <= bwss_events_t'(6'h20 >> i);
    @(posedge pclk);
    events <= '0;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the expected run
  initial
  begin
    #60000;
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h2000a0a4));
    rv = {$urandom, $urandom};
    win = rv[47:0];
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BWSS_IO_OFF, e1c(6'h00), 1'b0);
    rd(`BWSS_MEM_OFF, e20(), 1'b0);
    rd(`BWSS_IRQ_MSK_OFF, 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    // Random fill, reserved and fixed bits must survive
    repeat (8)
    begin
      d = $urandom;
      wr(`BWSS_IO_OFF, d);
      lim = d[15:12];
      rd(`BWSS_IO_OFF, e1c(6'h00), 1'b0);
      d = $urandom;
      wr(`BWSS_MEM_OFF, d);
      mb = d[15:4];
      rd(`BWSS_MEM_OFF, e20(), 1'b0);
    end
    wr(12'h040, 32'hffffffff);
    chk({31'h0, e}, 32'h1);
    rd(`BWSS_MEM_OFF, e20(), 1'b0);
    wr(`BWSS_IRQ_MSK_OFF, 32'h3f);
    // Each event sets its flag; zero write keeps it, one clears
    for (int i = 0; i < 6; i++)
    begin
      pulse(i);
      rd(`BWSS_IO_OFF, e1c(6'h01 << i), 1'b0);
      chk({31'h0, irq}, 32'h1);
      wr(`BWSS_IO_OFF, {16'h0, lim, 12'h000});
      rd(`BWSS_IRQ_STS_OFF, 32'h1 << i, 1'b0);
      wr(`BWSS_IO_OFF, (32'h1 << pos[i]) | {16'h0, lim, 12'h000});
      rd(`BWSS_IRQ_STS_OFF, 32'h0, 1'b0);
      chk({31'h0, irq}, 32'h0);
    end
    ctl <= 2'h0;
    pulse(0);
    pulse(4);
    rd(`BWSS_IRQ_STS_OFF, 32'h0, 1'b0);
    ctl <= 2'h3;
    pulse(5);
    wr(`BWSS_IRQ_MSK_OFF, 32'h1f);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`BWSS_IRQ_MSK_OFF, 32'h3f);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    // Event held across a clearing write wins
    events <= bwss_events_t'(6'h10);
    wr(`BWSS_IRQ_STS_OFF, 32'h22);
    events <= '0;
    rd(`BWSS_IRQ_STS_OFF, 32'h2, 1'b0);
    // Window edges: base, top, one above, one below
    repeat (24)
    begin
      rv = {$urandom, $urandom};
      w = rv[47:0];
      k = $urandom_range(3, 0);
      lo = {w.io_base_upper, w.io_base_nib, 12'h000};
      hi = {w.io_limit_upper, lim, 12'hfff};
      mlo = {mb, 20'h00000};
      mhi = {w.mem_limit, 20'hfffff};
      ia = corner(k, lo, hi);
      ma = corner(k, mlo, mhi);
      @(posedge pclk);
      win <= w;
      io_chk_addr <= ia;
      mem_chk_addr <= ma;
      repeat (2) @(posedge pclk);
      chk({31'h0, io_hit}, {31'h0, (ia >= lo) && (ia <= hi)});
      chk({31'h0, mem_hit}, {31'h0, (ma >= mlo) && (ma <= mhi)});
    end
    tally_and_finish();
  end
endmodule
